// [hdl/adc_ctl_defs.svh]
// Purpose: Offsets, field positions, reset values and timing for the converter control block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Definitions only
`ifndef ADC_CTL_DEFS_SVH
`define ADC_CTL_DEFS_SVH
// ==========================================
// Register byte offsets
`define OFS_SC1       8'h00
`define OFS_SC2       8'h04
`define OFS_RESULT    8'h08
`define OFS_CMPV      8'h0c
`define OFS_ISTAT     8'h10
`define OFS_IMASK     8'h14
// ==========================================
// Field values and reset values
`define CH_OFF        5'h1f
// Field positions and reset values of the control and interrupt registers
`define CH_MSB        4
`define SC1_IE_BIT    6
`define SC1_CONT_BIT  5
`define SC2_TRG_BIT   6
`define SC2_CMPEN_BIT 5
`define SC2_CMPGE_BIT 4
`define SC1_RST       8'h1f
`define IRQ_W         2
`define IRQ_DONE      0
`define IRQ_END       1
`define IMASK_RST     2'h3
// ==========================================
// Timing
`define CLK_PERIOD_NS 5
`define CONV_TIME_NS  2000
`endif

// [hdl/adc_ctl_pkg.sv]
// Purpose: Types shared by the converter control block
// Assumes: Nothing beyond the defs header
// Notes:   Structs carry bus requests and register images
package adc_ctl_pkg;
  // ==========================================
  // APB request from the master
  typedef struct packed {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_s;
  // First control register image
  typedef struct packed {
    logic       conversion_complete_flag;
    logic       complete_interrupt_enable;
    logic       cont;
    logic [4:0] ch;
  } sc1_s;
  // Second control register image
  typedef struct packed {
    logic       act;
    logic       trg;
    logic       compare_enable;
    logic       compare_greater_equal;
    logic [3:0] rsvd;
  } sc2_s;
  // Conversion sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } conv_state_e;
endpackage : adc_ctl_pkg

// [hdl/adc_control_status_regs.sv]
// Purpose: Control and status logic of a 10-bit converter behind APB
// Assumes: Sample data valid from the analog side at conversion end
// Notes:   Converter timing is a cycle counter; analog part is outside
`timescale 1ns/1ps
`include "adc_ctl_defs.svh"

module adc_control_status_regs #(
  parameter int RES_W = 10,
  parameter int CONV_CYCLES = (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire adc_ctl_pkg::apb_req_s apb_in,
  output logic [31:0]               prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  input  wire logic                 hardware_trigger_in,
  input  wire logic [RES_W-1:0]     sample_data_in,
  output logic [4:0]                channel_select_out,
  output logic                      converter_on_out,
  output logic                      irq_out
);
  import adc_ctl_pkg::*;

  // ==========================================
  // Storage
  conv_state_e      state_r;    // Sequencer state
  logic [15:0]      cnt_r;      // Cycles left in conversion
  sc1_s             sc1_r;      // First control register
  sc2_s             sc2_r;      // Second control register
  logic [RES_W-1:0] result_r;   // Last accepted result
  logic [RES_W-1:0] cmpv_r;     // Compare value
  logic [`IRQ_W-1:0] istat_r;   // Sticky event bits
  logic [`IRQ_W-1:0] imask_r;   // Event mask
  logic [31:0]      prdata_r;   // Read data latched in setup
  logic [2:0]       trg_sync_r; // Trigger synchroniser
  logic             trg_lvl_r;  // Filtered trigger level

  // ==========================================
  // Bus decode
  logic wr_acc;    // Write access completes
  logic rd_acc;    // Read access completes
  logic sc1_wr;    // First control register written
  logic sc2_wr;    // Second control register written
  logic res_rd;    // Result register read
  logic mapped;    // Address hits a register
  logic hw_edge;   // Hardware trigger assertion
  logic start_sw;  // Software start
  logic start_hw;  // Hardware start
  logic done;      // Conversion finishes this cycle
  logic done_eff;  // Completion not overridden by abort
  logic cmp_hit;   // Compare condition true
  logic cmp_ok;    // Result accepted
  logic restart;   // Back-to-back restart
  logic [15:0] conv_last; // Reload value of counter

  assign conv_last = 16'(CONV_CYCLES - 1);
  assign wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite;
  assign rd_acc = apb_in.psel && apb_in.penable && !apb_in.pwrite;
  assign sc1_wr = wr_acc && (apb_in.paddr == `OFS_SC1);
  assign sc2_wr = wr_acc && (apb_in.paddr == `OFS_SC2);
  assign res_rd = rd_acc && (apb_in.paddr == `OFS_RESULT);

  // Unmapped addresses answer with an error
  always_comb begin
    case (apb_in.paddr)
      `OFS_SC1, `OFS_SC2, `OFS_RESULT,
      `OFS_CMPV, `OFS_ISTAT, `OFS_IMASK: mapped = 1'b1;
      default:                           mapped = 1'b0;
    endcase
  end

  // Zero wait states; data was latched in the setup cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = apb_in.psel && apb_in.penable && !mapped;
  assign prdata_out  = prdata_r;

  // ==========================================
  // Hardware trigger synchroniser
  // Three stages; level moves only when stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      trg_sync_r <= 3'h0;
      trg_lvl_r  <= 1'b0;
    end else begin
      trg_sync_r <= {trg_sync_r[1:0], hardware_trigger_in};
      if (trg_sync_r[1] == trg_sync_r[2]) begin
        trg_lvl_r <= trg_sync_r[2];
      end
    end
  end

  // Counter overflow pulse is taken on its rising level
  assign hw_edge = trg_sync_r[1] && trg_sync_r[2] && !trg_lvl_r;

  // ==========================================
  // Start, completion and compare
  assign start_sw = sc1_wr && !sc2_r.trg && (apb_in.pwdata[`CH_MSB:0] != `CH_OFF);
  assign start_hw = sc2_r.trg && hw_edge && !sc1_wr && (state_r == ST_IDLE)
                    && (sc1_r.ch != `CH_OFF);
  assign done     = (state_r == ST_CONV) && (cnt_r == 16'h0);
  assign done_eff = done && !sc1_wr;
  // Direction bit picks less-than or greater-equal
  assign cmp_hit  = sc2_r.compare_greater_equal ? (sample_data_in >= cmpv_r)
                                                : (sample_data_in < cmpv_r);
  assign cmp_ok   = !sc2_r.compare_enable || cmp_hit;
  assign restart  = done_eff && sc1_r.cont && (sc1_r.ch != `CH_OFF);

  // ==========================================
  // Conversion sequencer
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
      cnt_r   <= 16'h0;
    end else if (sc1_wr) begin
      // Any write aborts; new start only for a live channel
      if (start_sw) begin
        state_r <= ST_CONV;
        cnt_r   <= conv_last;
      end else begin
        state_r <= ST_IDLE;
        cnt_r   <= 16'h0;
      end
    end else if (start_hw) begin
      state_r <= ST_CONV;
      cnt_r   <= conv_last;
    end else if (done) begin
      if (restart) begin
        cnt_r <= conv_last;
      end else begin
        state_r <= ST_IDLE;
      end
    end else if (state_r == ST_CONV) begin
      cnt_r <= cnt_r - 16'h1;
    end
  end

  // ==========================================
  // First control register and complete flag
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sc1_r <= sc1_s'(`SC1_RST);
    end else begin
      if (sc1_wr) begin
        sc1_r.complete_interrupt_enable <= apb_in.pwdata[`SC1_IE_BIT];
        sc1_r.cont                      <= apb_in.pwdata[`SC1_CONT_BIT];
        sc1_r.ch                        <= apb_in.pwdata[`CH_MSB:0];
      end
      // Write clears; completion beats a result read
      if (sc1_wr) begin
        sc1_r.conversion_complete_flag <= 1'b0;
      end else if (done_eff && cmp_ok) begin
        sc1_r.conversion_complete_flag <= 1'b1;
      end else if (res_rd) begin
        sc1_r.conversion_complete_flag <= 1'b0;
      end
    end
  end

  // ==========================================
  // Second control register; active flag is read-only
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sc2_r <= '0;
    end else if (sc2_wr) begin
      sc2_r.trg                   <= apb_in.pwdata[`SC2_TRG_BIT];
      sc2_r.compare_enable        <= apb_in.pwdata[`SC2_CMPEN_BIT];
      sc2_r.compare_greater_equal <= apb_in.pwdata[`SC2_CMPGE_BIT];
    end
  end

  // ==========================================
  // Result and compare value
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      result_r <= '0;
      cmpv_r   <= '0;
    end else begin
      if (done_eff && cmp_ok) begin
        result_r <= sample_data_in;
      end
      if (wr_acc && (apb_in.paddr == `OFS_CMPV)) begin
        cmpv_r <= apb_in.pwdata[RES_W-1:0];
      end
    end
  end

  // ==========================================
  // Interrupt status and mask; set wins over clear
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      istat_r <= '0;
      imask_r <= `IMASK_RST;
    end else begin
      if (wr_acc && (apb_in.paddr == `OFS_IMASK)) begin
        imask_r <= apb_in.pwdata[`IRQ_W-1:0];
      end
      istat_r[`IRQ_DONE] <= (done_eff && cmp_ok && sc1_r.complete_interrupt_enable)
          || (istat_r[`IRQ_DONE]
              && !(wr_acc && (apb_in.paddr == `OFS_ISTAT) && apb_in.pwdata[`IRQ_DONE]));
      istat_r[`IRQ_END] <= done_eff
          || (istat_r[`IRQ_END]
              && !(wr_acc && (apb_in.paddr == `OFS_ISTAT) && apb_in.pwdata[`IRQ_END]));
    end
  end

  assign irq_out = |(istat_r & imask_r);

  // ==========================================
  // Read data, latched in the setup cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      prdata_r <= 32'h0;
    end else if (apb_in.psel && !apb_in.penable) begin
      case (apb_in.paddr)
        `OFS_SC1:    prdata_r <= {24'h0, sc1_r};
        // Reserved bits read zero whatever was written
        `OFS_SC2:    prdata_r <= {24'h0, (state_r == ST_CONV), sc2_r.trg,
                                  sc2_r.compare_enable, sc2_r.compare_greater_equal, 4'h0};
        `OFS_RESULT: prdata_r <= 32'(result_r);
        `OFS_CMPV:   prdata_r <= 32'(cmpv_r);
        `OFS_ISTAT:  prdata_r <= 32'(istat_r);
        `OFS_IMASK:  prdata_r <= 32'(imask_r);
        default:     prdata_r <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // Analog side controls
  assign channel_select_out = sc1_r.ch;
  assign converter_on_out   = (state_r == ST_CONV);

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_sw_start;
    sc1_wr && !sc2_r.trg && (apb_in.pwdata[`CH_MSB:0] != `CH_OFF);
  endsequence

  // Control one write with the disable code
  sequence s_off_write;
    sc1_wr && (apb_in.pwdata[`CH_MSB:0] == `CH_OFF);
  endsequence

  sequence s_accept;
    done_eff && cmp_ok;
  endsequence

  // Completion with a failed compare and no result read
  sequence s_cmp_miss;
    done_eff && sc2_r.compare_enable && !cmp_hit && !res_rd;
  endsequence

  // Completion interrupt enabled and unmasked
  sequence s_irq_armed;
    sc1_r.complete_interrupt_enable && imask_r[`IRQ_DONE];
  endsequence

  AST_ABORT_START: assert property (s_sw_start |=> converter_on_out && cnt_r == conv_last)
    else $error("Control one write did not restart conversion");

  AST_OFF_CODE: assert property (s_off_write |=> !converter_on_out [*2])
    else $error("Disable code left converter running");

  AST_FLAG_SET: assert property (done_eff && !sc2_r.compare_enable |=> sc1_r.conversion_complete_flag)
    else $error("Complete flag not set");

  AST_CMP_MISS: assert property (s_cmp_miss |=> $stable(sc1_r.conversion_complete_flag))
    else $error("Complete flag changed on failed compare");

  AST_FLAG_CLR: assert property (sc1_wr |=> !sc1_r.conversion_complete_flag)
    else $error("Complete flag not cleared by write");

  AST_IRQ_RAISE: assert property (s_accept ##0 s_irq_armed |=> irq_out)
    else $error("Interrupt not raised");

  AST_SINGLE_END: assert property (done_eff && !sc1_r.cont |=> !converter_on_out)
    else $error("Single conversion did not stop");

  // Back-to-back restart reloads the full conversion count at once
  AST_CONT_RUN: assert property (restart |=> converter_on_out && cnt_r == conv_last)
    else $error("Continuous conversion did not repeat");

  AST_RESULT: assert property (s_accept |=> result_r == $past(sample_data_in))
    else $error("Result not loaded");

  AST_SC2_QUIET: assert property (sc2_wr && state_r == ST_CONV && cnt_r != 16'h0 |=> converter_on_out)
    else $error("Control two write disturbed conversion");

  AST_ACTIVE: assert property (start_hw |=> converter_on_out && cnt_r == conv_last)
    else $error("Active flag wrong at hardware start");

endmodule : adc_control_status_regs

// [dv/trig_model.sv]
// Purpose: Periodic trigger source for the wake-up counter side
// Assumes: Each overflow shows as a 4-cycle high level
// Notes:   Silent and reset to zero while disabled
`timescale 1ns/1ps
module trig_model #(
  parameter int PERIOD = 40
) (
  input  wire logic clk_in,
  input  wire logic en_in,
  output logic      trig_out
);
  // ==========================================
  // Overflow counter
  int cnt_r;  // Cycles since last overflow
  // Count while enabled, restart when disabled
  always_ff @(posedge clk_in) begin
    cnt_r <= (!en_in || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
  end
  // High near each overflow
  assign trig_out = en_in && (cnt_r >= PERIOD - 4);
endmodule : trig_model

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the converter control block
// Assumes: Short conversion time set through CONV_CYCLES
// Notes:   APB master tasks; trigger comes from the partner model
`timescale 1ns/1ps
`include "adc_ctl_defs.svh"
module tb_top;
  import adc_ctl_pkg::*;
  // ==========================================
  // Signals
  localparam int CC = 8;  // Short conversion
  logic        clk_in;
  logic        resetn_in;
  apb_req_s    apb_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        trig;       // From model
  logic        trig_en;    // Model enable
  logic [9:0]  sample;     // Converter sample
  logic [4:0]  chan;       // Channel out
  logic        conv_on;    // Running
  logic        irq_out;
  logic [31:0] rd;         // Last read data
  logic        rerr;       // Last error response
  int          err_count;
  int          checked;
  // ==========================================
  // Instances
  adc_control_status_regs #(.CONV_CYCLES(CC)) u_adc_control_status_regs (
    .clk_in(clk_in), .resetn_in(resetn_in), .apb_in(apb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .hardware_trigger_in(trig),
    .sample_data_in(sample), .channel_select_out(chan), .converter_on_out(conv_on),
    .irq_out(irq_out));
  trig_model #(.PERIOD(40)) u_trig_model (.clk_in(clk_in), .en_in(trig_en), .trig_out(trig));
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    apb_in <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
    @(posedge clk_in);
    apb_in.penable <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    rerr = pslverr_out;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
  endtask : bus
  // Wait until the running conversion ends
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk_in);
    while (conv_on === 1'b1 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
  endtask : wait_idle
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // ==========================================
  // Scenarios
  task automatic t_reset();
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk(rd, 32'h1f, "sc1 rst");
    bus(`OFS_SC2, 1'b0, 32'h0);
    chk(rd, 32'h0, "sc2 rst");
    bus(`OFS_IMASK, 1'b0, 32'h0);
    chk(rd, 32'h3, "imask rst");
    bus(8'h18, 1'b0, 32'h0);
    chk({rd[30:0], rerr}, 32'h1, "unmapped");
    chk({chan, conv_on, irq_out}, 32'h7c, "pins rst");
    $display("reset test done");
  endtask : t_reset
  task automatic t_single();
    sample <= 10'h2a5;
    bus(`OFS_SC1, 1'b1, 32'h43);
    @(posedge clk_in);
    chk(chan, 32'h3, "channel");
    bus(`OFS_SC2, 1'b0, 32'h0);
    chk(rd, 32'h80, "active");
    wait_idle();
    chk(conv_on, 32'h0, "power down");
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk(rd, 32'hc3, "complete");
    chk(irq_out, 32'h1, "irq");
    bus(`OFS_RESULT, 1'b0, 32'h0);
    chk(rd, 32'h2a5, "result");
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk(rd, 32'h43, "read clears");
    repeat (20) @(posedge clk_in);
    chk(conv_on, 32'h0, "one only");
    bus(`OFS_ISTAT, 1'b0, 32'h0);
    chk(rd, 32'h3, "istat");
    bus(`OFS_IMASK, 1'b1, 32'h1);
    bus(`OFS_ISTAT, 1'b1, 32'h1);
    @(posedge clk_in);
    chk(irq_out, 32'h0, "masked");
    bus(`OFS_ISTAT, 1'b1, 32'h2);
    bus(`OFS_IMASK, 1'b1, 32'h3);
    @(posedge clk_in);
    chk(irq_out, 32'h0, "cleared");
    $display("single test done");
  endtask : t_single
  task automatic t_compare();
    sample <= 10'h100;
    bus(`OFS_CMPV, 1'b1, 32'h100);
    bus(`OFS_SC2, 1'b1, 32'h20);
    bus(`OFS_SC1, 1'b1, 32'h05);
    wait_idle();
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk(rd, 32'h05, "lt false");
    bus(`OFS_RESULT, 1'b0, 32'h0);
    chk(rd, 32'h2a5, "kept");
    bus(`OFS_SC2, 1'b1, 32'h30);
    bus(`OFS_SC1, 1'b1, 32'h05);
    wait_idle();
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk(rd, 32'h85, "ge equal");
    bus(`OFS_RESULT, 1'b0, 32'h0);
    chk(rd, 32'h100, "loaded");
    bus(`OFS_SC2, 1'b1, 32'h0);
    $display("compare test done");
  endtask : t_compare
  task automatic t_cont();
    bus(`OFS_SC1, 1'b1, 32'h21);
    repeat (CC + 6) @(posedge clk_in);
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk({rd[7:0], conv_on}, 32'h143, "repeat");
    bus(`OFS_SC2, 1'b1, 32'h0);
    bus(`OFS_SC2, 1'b0, 32'h0);
    chk(rd, 32'h80, "sc2 no abort");
    bus(`OFS_SC1, 1'b1, 32'h21);
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk({rd[7:0], conv_on}, 32'h43, "restart");
    bus(`OFS_SC1, 1'b1, 32'h1f);
    repeat (20) @(posedge clk_in);
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk({rd[7:0], conv_on}, 32'h3e, "disabled");
    $display("continuous test done");
  endtask : t_cont
  task automatic t_hw();
    int n;
    n = 0;
    bus(`OFS_SC2, 1'b1, 32'h40);
    bus(`OFS_SC1, 1'b1, 32'h02);
    repeat (3) @(posedge clk_in);
    chk(conv_on, 32'h0, "no sw start");
    trig_en <= 1'b1;
    while (conv_on !== 1'b1 && n < 80) begin
      @(posedge clk_in);
      n++;
    end
    chk(conv_on, 32'h1, "hw start");
    trig_en <= 1'b0;
    wait_idle();
    bus(`OFS_SC1, 1'b0, 32'h0);
    chk({rd[7:0], conv_on}, 32'h104, "hw done");
    $display("hardware trigger test done");
  endtask : t_hw
  // ==========================================
  // Clock, sequence and watchdog
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    resetn_in = 1'b0;
    apb_in = '0;
    trig_en = 1'b0;
    sample = '0;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_single();
    t_compare();
    t_cont();
    t_hw();
    print_verdict();
  end
  initial begin
    #50000;
    err_count++;
    print_verdict();
  end
endmodule : tb_top
